// [rtcu_defs.vh]
// Constants for the rotate-through-carry unit
`ifndef RTCU_DEFS_VH
`define RTCU_DEFS_VH
`define RTCU_DW 8
`define RTCU_AW 8
`define RTCU_DEPTH 192
`define RTCU_MSB 7
`define RTCU_LSB 0
// Operation codes
`define RTCU_OPW 3
`define RTCU_OP_LEFT_CY_MEM 3'h0
`define RTCU_OP_LEFT_CY_WREG 3'h1
`define RTCU_OP_RIGHT_MEM 3'h2
`define RTCU_OP_RIGHT_WREG 3'h3
`define RTCU_OP_RIGHT_CY_MEM 3'h4
`define RTCU_OP_RIGHT_CY_WREG 3'h5
// One-hot states
`define RTCU_SW 3
`define RTCU_ST_IDLE 3'h1
`define RTCU_ST_READ 3'h2
`define RTCU_ST_EXEC 3'h4
// Reset values
`define RTCU_WREG_RST 8'h00
`define RTCU_CY_RST 1'h0
`define RTCU_RESULT_RST 8'h00
`endif

// [rtcu_dmem.v]
// Small data memory with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "rtcu_defs.vh"
module rtcu_dmem #(
  parameter DW = `RTCU_DW,
  parameter AW = `RTCU_AW,
  parameter DEPTH = `RTCU_DEPTH
) (
  input wire clk,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata_q,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata
);
  reg [DW-1:0] mem [0:DEPTH-1];

  // Write port and registered read port
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule
`default_nettype wire

// [rtcu_unit.v]
// Rotate datapath with carry flag, working register and data memory
`timescale 1ns/1ps
`default_nettype none
`include "rtcu_defs.vh"
// Contract
// - Memory rotate left through carry: old carry to bit 0, bit 7 to carry.
// - Same rotate left to working register, carry from bit 7, memory kept.
// - Memory rotate right: bit 0 into bit 7, no flag changes.
// - Rotate right to working register, memory and carry untouched.
// - Memory rotate right through carry: old carry to bit 7, bit 0 to carry.
// - Same rotate right to working register, carry from bit 0, memory kept.
module rtcu_unit #(
  parameter DW = `RTCU_DW,
  parameter AW = `RTCU_AW,
  parameter DEPTH = `RTCU_DEPTH
) (
  input wire clk,
  input wire reset,
  input wire start,
  input wire [`RTCU_OPW-1:0] op,
  input wire [AW-1:0] addr,
  input wire cy_load,
  input wire cy_in,
  input wire wreg_load,
  input wire [DW-1:0] wreg_in,
  output wire busy,
  output reg done_q,
  output reg cy_q,
  output reg [DW-1:0] working_register_q,
  output reg [DW-1:0] result_q
);
  // One-hot sequencer states
  localparam [`RTCU_SW-1:0] ST_IDLE = `RTCU_ST_IDLE;
  localparam [`RTCU_SW-1:0] ST_READ = `RTCU_ST_READ;
  localparam [`RTCU_SW-1:0] ST_EXEC = `RTCU_ST_EXEC;

  // Sequencer state
  reg [`RTCU_SW-1:0] state_q;
  reg [`RTCU_SW-1:0] state_d;

  // Instruction latched when a request is taken
  reg [`RTCU_OPW-1:0] op_q;
  reg [AW-1:0] addr_q;

  // Controls decoded from the latched instruction
  reg rotate;
  reg dir_left;
  reg thru_cy;
  reg to_mem;
  reg to_wreg;
  reg upd_cy;

  // Operand from memory and the two rotate networks
  wire [DW-1:0] opnd;
  wire [DW-1:0] rot_left;
  wire [DW-1:0] rot_right;
  reg [DW-1:0] rot;
  reg new_cy;

  // Handshake and phase strobes
  wire take;
  wire exec;
  wire mem_we;

  // Next values of the registered outputs
  reg done_d;
  reg cy_d;
  reg [DW-1:0] working_register_d;
  reg [DW-1:0] result_d;

  // Per-bit generate index
  genvar gi;

  // Busy covers the read and execute cycles; start is ignored meanwhile
  assign busy = (state_q != ST_IDLE);
  assign take = start && !busy;
  assign exec = (state_q == ST_EXEC);
  // Only memory variants write, and only in their execute cycle
  assign mem_we = exec && to_mem;

  // Memory read at the latched address, write back to the same one
  rtcu_dmem #(.DW(DW), .AW(AW), .DEPTH(DEPTH)) u_mem (
    .clk(clk),
    .raddr(addr_q),
    .rdata_q(opnd),
    .we(mem_we),
    .waddr(addr_q),
    .wdata(rot)
  );

  // Instruction decode; unused codes pass the operand and store nothing
  always @* begin
    rotate = 1'h0;
    dir_left = 1'h0;
    thru_cy = 1'h0;
    to_mem = 1'h0;
    to_wreg = 1'h0;
    upd_cy = 1'h0;
    case (op_q)
      `RTCU_OP_LEFT_CY_MEM: begin
        rotate = 1'h1;
        dir_left = 1'h1;
        thru_cy = 1'h1;
        to_mem = 1'h1;
        upd_cy = 1'h1;
      end
      `RTCU_OP_LEFT_CY_WREG: begin
        rotate = 1'h1;
        dir_left = 1'h1;
        thru_cy = 1'h1;
        to_wreg = 1'h1;
        upd_cy = 1'h1;
      end
      `RTCU_OP_RIGHT_MEM: begin
        rotate = 1'h1;
        to_mem = 1'h1;
      end
      `RTCU_OP_RIGHT_WREG: begin
        rotate = 1'h1;
        to_wreg = 1'h1;
      end
      `RTCU_OP_RIGHT_CY_MEM: begin
        rotate = 1'h1;
        thru_cy = 1'h1;
        to_mem = 1'h1;
        upd_cy = 1'h1;
      end
      `RTCU_OP_RIGHT_CY_WREG: begin
        rotate = 1'h1;
        thru_cy = 1'h1;
        to_wreg = 1'h1;
        upd_cy = 1'h1;
      end
      default: begin
        rotate = 1'h0;
      end
    endcase
  end

  // Per-bit rotate networks; the end bits take the carry or the far end
  generate
    for (gi = 0; gi < DW; gi = gi + 1) begin : g_bit
      if (gi == `RTCU_LSB) begin : g_lsb
        assign rot_left[gi] = thru_cy ? cy_q : opnd[DW-1];
      end else begin : g_up
        assign rot_left[gi] = opnd[gi-1];
      end
      if (gi == DW-1) begin : g_msb
        assign rot_right[gi] = thru_cy ? cy_q : opnd[`RTCU_LSB];
      end else begin : g_down
        assign rot_right[gi] = opnd[gi+1];
      end
    end
  endgenerate

  // Result select; the new carry comes from the unrotated operand
  always @* begin
    rot = opnd;
    new_cy = cy_q;
    if (rotate) begin
      if (dir_left) begin
        rot = rot_left;
        new_cy = opnd[`RTCU_MSB];
      end else begin
        rot = rot_right;
        new_cy = opnd[`RTCU_LSB];
      end
    end
  end

  // Sequencer: idle, operand read, execute
  always @* begin
    case (state_q)
      ST_IDLE: begin
        state_d = take ? ST_READ : ST_IDLE;
      end
      ST_READ: begin
        state_d = ST_EXEC;
      end
      ST_EXEC: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Next values; the execute cycle wins over a load from outside
  always @* begin
    done_d = exec;
    cy_d = cy_q;
    working_register_d = working_register_q;
    result_d = result_q;
    if (exec) begin
      result_d = rot;
      if (upd_cy) begin
        cy_d = new_cy;
      end
      if (to_wreg) begin
        working_register_d = rot;
      end
    end else begin
      if (cy_load) begin
        cy_d = cy_in;
      end
      if (wreg_load) begin
        working_register_d = wreg_in;
      end
    end
  end

  // Sequencer state and instruction latch
  always @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      op_q <= `RTCU_OP_RIGHT_WREG;
      addr_q <= {AW{1'h0}};
    end else begin
      state_q <= state_d;
      if (take) begin
        op_q <= op;
        addr_q <= addr;
      end
    end
  end

  // Done pulse, carry flag, working register and result
  always @(posedge clk) begin
    if (reset) begin
      done_q <= 1'h0;
      cy_q <= `RTCU_CY_RST;
      working_register_q <= `RTCU_WREG_RST;
      result_q <= `RTCU_RESULT_RST;
    end else begin
      done_q <= done_d;
      cy_q <= cy_d;
      working_register_q <= working_register_d;
      result_q <= result_d;
    end
  end
endmodule
`default_nettype wire

// [rtcu_unit_asserts.sv]
// Checker for the rotate unit
`timescale 1ns/1ps
`default_nettype none
module rtcu_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic busy,
  input wire logic [2:0] op,
  input wire logic done_q,
  input wire logic cy_q,
  input wire logic [7:0] working_register_q,
  input wire logic [7:0] result_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_done_on_time: assert property (start && !busy |-> ##3 done_q)
    else $error("done late");
  a_done_one_pulse: assert property (done_q |=> !done_q)
    else $error("done longer than one cycle");
  a_busy_on_take: assert property (start && !busy |=> busy)
    else $error("request not taken");
  a_left_old_cy: assert property (start && !busy && op == 3'h0 |->
    ##3 result_q[0] == $past(cy_q, 3)) else $error("left rotate bit 0");
  a_right_mem_cy: assert property (start && !busy && op == 3'h4 |->
    ##3 result_q[7] == $past(cy_q, 3)) else $error("right memory bit 7");
  a_right_old_cy: assert property (start && !busy && op == 3'h5 |->
    ##3 result_q[7] == $past(cy_q, 3)) else $error("right rotate bit 7");
  a_plain_cy_kept: assert property (start && !busy && op[2:1] == 2'h1 |->
    ##3 cy_q == $past(cy_q, 3)) else $error("plain rotate carry");
  a_wreg_gets_rot: assert property (start && !busy && op[0] &&
    op != 3'h7 |-> ##3 working_register_q == result_q)
    else $error("working register not loaded");
  a_mem_wreg_kept: assert property (start && !busy && !op[0] |->
    ##3 working_register_q == $past(working_register_q, 3))
    else $error("working register changed");
endmodule
bind rtcu_unit rtcu_chk u_chk (.clk(clk), .reset(reset), .start(start),
  .busy(busy), .op(op), .done_q(done_q), .cy_q(cy_q),
  .working_register_q(working_register_q), .result_q(result_q));
`default_nettype wire

// [rtcu_dec.sv]
// Decoder model issuing one rotate at a time
`timescale 1ns/1ps
`default_nettype none
module rtcu_dec (
  input wire logic clk,
  output logic start,
  output logic [2:0] op,
  output logic [7:0] addr
);
  initial begin
    start = 1'h0;
    op = 3'h0;
    addr = 8'h00;
  end
  // One-cycle start, then two edges until done and results stand
  task automatic issue(input logic [2:0] o, input logic [7:0] a);
    @(posedge clk);
    start <= 1'h1;
    op <= o;
    addr <= a;
    @(posedge clk);
    start <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// [rtcu_unit_bench.sv]
// Bench for the rotate unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
module rtcu_unit_bench;
  logic clk, reset, cy_load, cy_in, wreg_load, start, busy, done_q, cy_q;
  logic [2:0] op;
  logic [7:0] addr, wreg_in, wreg_q, result_q;
  integer num_errors = 0, total_checks = 0;
  rtcu_unit u_dut (.clk(clk), .reset(reset), .start(start), .op(op),
    .addr(addr), .cy_load(cy_load), .cy_in(cy_in), .wreg_load(wreg_load),
    .wreg_in(wreg_in), .busy(busy), .done_q(done_q), .cy_q(cy_q),
    .working_register_q(wreg_q), .result_q(result_q));
  rtcu_dec u_dec (.clk(clk), .start(start), .op(op), .addr(addr));
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Preload operand and carry, run one instruction, judge every output
  task automatic run_op(input logic [2:0] o, input logic c,
                        input logic [7:0] m);
    logic [7:0] a, r;
    logic n;
    a = 8'hbf - o;
    u_dut.u_mem.mem[a] = m;
    @(posedge clk);
    {cy_in, cy_load, wreg_in, wreg_load} <= {c, 1'h1, 8'h5a, 1'h1};
    @(posedge clk);
    {cy_load, wreg_load} <= 2'h0;
    n = (o < 3'h6); // Codes 6 and 7 rotate nothing and store nothing
    r = o[2] ? {c, m[7:1]} : o[1] ? {m[0], m[7:1]} : {m[6:0], c};
    r = n ? r : m;
    u_dec.issue(o, a);
    `CHK("done", 1'h1, done_q)
    `CHK("busy", 1'h0, busy)
    `CHK("result", r, result_q)
    `CHK("carry", !n ? c : o[2] ? m[0] : o[1] ? c : m[7], cy_q)
    `CHK("wreg", n && o[0] ? r : 8'h5a, wreg_q)
    `CHK("mem", !n || o[0] ? m : r, u_dut.u_mem.mem[a])
  endtask
  // Reset while idle clears busy, done, carry, working register, result
  task automatic reset_check;
    @(posedge clk);
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    #1;
    `CHK("busy", 1'h0, busy)
    `CHK("done", 1'h0, done_q)
    `CHK("carry", 1'h0, cy_q)
    `CHK("wreg", 8'h00, wreg_q)
    `CHK("result", 8'h00, result_q)
  endtask
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Cycle ceiling against a hang
  initial begin
    repeat (2000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
  // Every op code with both carry values, then a reset while idle
  initial begin
    {reset, cy_load, cy_in, wreg_load, wreg_in} = {4'h8, 8'h00};
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    for (int i = 0; i < 16; i++) begin
      run_op(3'(i / 2), i[0], i[1] ? 8'h69 : 8'h96);
    end
    reset_check();
    run_op(3'h1, 1'h1, 8'h3c);
    end_of_test();
  end
endmodule
`default_nettype wire
